// file: dlgc_pkg.sv
package dlgc_pkg;

  localparam logic [7:0] DLGC_ADDR_FREQ_OFFSET_COMP_CONFIG = 8'h19;
  localparam logic [7:0] DLGC_ADDR_BIT_SYNC_CONFIG         = 8'h1A;

  localparam int DLGC_LOOP_FREEZE_BIT    = 5;
  localparam int DLGC_FREQ_PRE_MSB       = 4;
  localparam int DLGC_FREQ_PRE_LSB       = 3;
  localparam int DLGC_FREQ_POST_BIT      = 2;
  localparam int DLGC_FREQ_SAT_MSB       = 1;
  localparam int DLGC_FREQ_SAT_LSB       = 0;
  localparam int DLGC_CLKREC_KI_MSB      = 7;
  localparam int DLGC_CLKREC_KI_LSB      = 6;
  localparam int DLGC_CLKREC_KP_MSB      = 5;
  localparam int DLGC_CLKREC_KP_LSB      = 4;

  localparam logic       DLGC_RST_LOOP_FREEZE = 1'h1;
  localparam logic [1:0] DLGC_RST_FREQ_PRE    = 2'h2;
  localparam logic       DLGC_RST_FREQ_POST   = 1'h1;
  localparam logic [1:0] DLGC_RST_FREQ_SAT    = 2'h2;
  localparam logic [1:0] DLGC_RST_CLKREC_KI   = 2'h1;
  localparam logic [1:0] DLGC_RST_CLKREC_KP   = 2'h2;
  localparam logic [3:0] DLGC_RST_BIT_SYNC_CONFIG_LOW   = 4'h0;
  localparam logic [3:0] DLGC_RST_FREQ_GAIN   = 4'h6;
  localparam logic [3:0] DLGC_RST_KI_GAIN     = 4'h4;

  // gains in units of K/2: K/2=1, K=2, 2K=4, 3K=6, 4K=8
  localparam int DLGC_GAIN_W = 4;
  localparam logic [3:0] DLGC_GAIN_HALF_K = 4'h1;

  // saturation as divider shift of channel bandwidth, 0 means off
  localparam int DLGC_SAT_W = 2;

  typedef enum logic [0:0] {DLGC_SEARCH, DLGC_LOCKED} dlgc_phase_t;

endpackage : dlgc_pkg

// file: dlgc_gain_map.sv
`timescale 1ns/1ps
module dlgc_gain_map (
  input  wire logic [1:0] sel,
  output logic      [3:0] gain
);
  import dlgc_pkg::*;
  // 00..11 gives 1x..4x base, expressed in half-base units
  always_comb begin
    gain = {1'b0, sel, 1'b0} + 4'h2;
  end
endmodule // dlgc_gain_map

// file: dlgc_loop_gain_control.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - freeze both loops until carrier sense high
// - pre-sync frequency gain K to 4K
// - post-sync frequency gain pre or K/2
// - frequency compensation saturation limit select
// - pre-sync clock recovery integral gain KI..4KI
// - pre-sync clock recovery proportional gain select
module dlgc_loop_gain_control (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire logic                          sync_detect,
  input  wire logic                          search_start,
  input  wire logic                          carrier_sense,
  output logic      [dlgc_pkg::DLGC_GAIN_W-1:0] freq_gain,
  output logic      [dlgc_pkg::DLGC_SAT_W-1:0]  freq_comp_saturation,
  output logic      [dlgc_pkg::DLGC_GAIN_W-1:0] clkrec_integral_gain,
  output logic      [1:0]                    clkrec_proportional_sel,
  output logic                               loops_frozen,
  output logic                               sync_phase
);
  import dlgc_pkg::*;

  typedef struct packed {
    logic        loop_freeze_until_carrier;
    logic [1:0]  freq_gain_pre_sync;
    logic        freq_gain_post_sync;
    logic [1:0]  freq_comp_saturation;
    logic [1:0]  clkrec_integral_pre_sync;
    logic [1:0]  clkrec_proportional_pre_sync;
    logic [3:0]  bit_sync_config_low;
    dlgc_phase_t phase;
    logic        carrier_seen;
    logic        cs_meta;
    logic        cs_sync;
    logic [7:0]  rdata;
    logic [3:0]  freq_gain;
    logic [3:0]  ki_gain;
    logic [1:0]  kp_sel;
    logic        frozen;
  } dlgc_state_t;

  dlgc_state_t st;
  dlgc_state_t next_st;
  logic [3:0]  pre_freq_gain;
  logic [3:0]  pre_ki_gain;
  logic        locked_now;

  dlgc_gain_map u_freq_map (
    .sel  (next_st.freq_gain_pre_sync),
    .gain (pre_freq_gain)
  );

  dlgc_gain_map u_ki_map (
    .sel  (next_st.clkrec_integral_pre_sync),
    .gain (pre_ki_gain)
  );

  always_comb begin
    next_st = st;
    next_st.cs_meta = carrier_sense;
    next_st.cs_sync = st.cs_meta;
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        DLGC_ADDR_FREQ_OFFSET_COMP_CONFIG: begin
          next_st.loop_freeze_until_carrier = reg_wdata[DLGC_LOOP_FREEZE_BIT];
          next_st.freq_gain_pre_sync = reg_wdata[DLGC_FREQ_PRE_MSB:DLGC_FREQ_PRE_LSB];
          next_st.freq_gain_post_sync = reg_wdata[DLGC_FREQ_POST_BIT];
          next_st.freq_comp_saturation = reg_wdata[DLGC_FREQ_SAT_MSB:DLGC_FREQ_SAT_LSB];
        end
        DLGC_ADDR_BIT_SYNC_CONFIG: begin
          next_st.clkrec_integral_pre_sync = reg_wdata[DLGC_CLKREC_KI_MSB:DLGC_CLKREC_KI_LSB];
          next_st.clkrec_proportional_pre_sync = reg_wdata[DLGC_CLKREC_KP_MSB:DLGC_CLKREC_KP_LSB];
          next_st.bit_sync_config_low = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // reads: reserved bits as zero, unmapped as zero
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        DLGC_ADDR_FREQ_OFFSET_COMP_CONFIG: begin
          next_st.rdata = {2'b00, st.loop_freeze_until_carrier, st.freq_gain_pre_sync,
                           st.freq_gain_post_sync, st.freq_comp_saturation};
        end
        DLGC_ADDR_BIT_SYNC_CONFIG: begin
          next_st.rdata = {st.clkrec_integral_pre_sync, st.clkrec_proportional_pre_sync, st.bit_sync_config_low};
        end
        default: begin
        end
      endcase
    end
    // packet phase; sync wins over a same-cycle search restart
    if (sync_detect) begin
      next_st.phase = DLGC_LOCKED;
    end else if (search_start) begin
      next_st.phase = DLGC_SEARCH;
    end
    // carrier latch, cleared when a new search begins
    if (search_start && !sync_detect) begin
      next_st.carrier_seen = 1'b0;
    end
    if (st.cs_sync) begin
      next_st.carrier_seen = 1'b1;
    end
    next_st.frozen = next_st.loop_freeze_until_carrier && !next_st.carrier_seen;
    locked_now = (next_st.phase == DLGC_LOCKED);
    // frequency loop gain
    if (locked_now && next_st.freq_gain_post_sync) begin
      next_st.freq_gain = DLGC_GAIN_HALF_K;
    end else begin
      next_st.freq_gain = pre_freq_gain;
    end
    // clock recovery: post-sync settings live beyond this register pair
    next_st.ki_gain = pre_ki_gain;
    next_st.kp_sel = next_st.clkrec_proportional_pre_sync;
    if (rst) begin
      next_st = '0;
      next_st.loop_freeze_until_carrier = DLGC_RST_LOOP_FREEZE;
      next_st.freq_gain_pre_sync = DLGC_RST_FREQ_PRE;
      next_st.freq_gain_post_sync = DLGC_RST_FREQ_POST;
      next_st.freq_comp_saturation = DLGC_RST_FREQ_SAT;
      next_st.clkrec_integral_pre_sync = DLGC_RST_CLKREC_KI;
      next_st.clkrec_proportional_pre_sync = DLGC_RST_CLKREC_KP;
      next_st.bit_sync_config_low = DLGC_RST_BIT_SYNC_CONFIG_LOW;
      next_st.phase = DLGC_SEARCH;
      next_st.frozen = DLGC_RST_LOOP_FREEZE;
      next_st.freq_gain = DLGC_RST_FREQ_GAIN;
      next_st.ki_gain = DLGC_RST_KI_GAIN;
      next_st.kp_sel = DLGC_RST_CLKREC_KP;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign reg_rdata               = st.rdata;
  assign freq_gain               = st.freq_gain;
  assign freq_comp_saturation    = st.freq_comp_saturation;
  assign clkrec_integral_gain    = st.ki_gain;
  assign clkrec_proportional_sel = st.kp_sel;
  assign loops_frozen            = st.frozen;
  assign sync_phase              = (st.phase == DLGC_LOCKED);

endmodule // dlgc_loop_gain_control

// file: dlgc_sva.sv
`timescale 1ns/1ps
module dlgc_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       sync_detect,
  input wire logic       carrier_sense,
  input wire logic [3:0] freq_gain,
  input wire logic [1:0] freq_comp_saturation,
  input wire logic [3:0] clkrec_integral_gain,
  input wire logic [1:0] clkrec_proportional_sel,
  input wire logic       loops_frozen,
  input wire logic       sync_phase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic w19, w1a, pre19;
  assign w19   = reg_wr && reg_addr == 8'h19;
  assign w1a   = reg_wr && reg_addr == 8'h1A;
  assign pre19 = w19 && !sync_phase && !sync_detect;
  property p_pre; pre19 |=> freq_gain == 4'h2 * ($past(reg_wdata[4:3]) + 4'h1); endproperty
  a_pre: assert property (p_pre) else $error("pre gain");
  property p_post; $rose(sync_phase) |-> freq_gain == 4'h1 || freq_gain == $past(freq_gain); endproperty
  a_post: assert property (p_post) else $error("post gain");
  property p_sat; w19 |=> freq_comp_saturation == $past(reg_wdata[1:0]); endproperty
  a_sat: assert property (p_sat) else $error("limit");
  property p_ki; w1a |=> clkrec_integral_gain == 4'h2 * ($past(reg_wdata[7:6]) + 4'h1); endproperty
  a_ki: assert property (p_ki) else $error("ki");
  property p_kp; w1a |=> clkrec_proportional_sel == $past(reg_wdata[5:4]); endproperty
  a_kp: assert property (p_kp) else $error("kp");
  property p_sync; sync_detect |=> sync_phase; endproperty
  a_sync: assert property (p_sync) else $error("sync");
  property p_frz; $fell(loops_frozen) |-> $past(carrier_sense, 3) || $past(w19); endproperty
  a_frz: assert property (p_frz) else $error("freeze");
endmodule // dlgc_sva

// file: dlgc_loop_gain_control_test.sv
`timescale 1ns/1ps
module dlgc_loop_gain_control_test;
  logic       sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sync_detect = 0, search_start = 0, carrier_sense = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] freq_gain, clkrec_integral_gain;
  logic [1:0] freq_comp_saturation, clkrec_proportional_sel;
  logic       loops_frozen, sync_phase;
  int         bad_count = 0, checked = 0, cyc = 0;
  wire  [7:0] o1 = {freq_gain, clkrec_integral_gain};
  wire  [7:0] o2 = {sync_phase, loops_frozen, 2'b00, clkrec_proportional_sel, freq_comp_saturation};
  always #2 sys_clk = ~sys_clk;
  dlgc_loop_gain_control DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sync_detect,
    .search_start, .carrier_sense, .freq_gain, .freq_comp_saturation, .clkrec_integral_gain,
    .clkrec_proportional_sel, .loops_frozen, .sync_phase);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  task automatic pulse(input logic s);
    @(posedge sys_clk);
    sync_detect <= s;
    search_start <= !s;
    @(posedge sys_clk);
    sync_detect <= 1'b0;
    search_start <= 1'b0;
    #1;
  endtask
  task automatic end_of_test();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(o1, 8'h64);
    chk(o2, 8'h4A);
    bus(0, 8'h19, 8'h36);
    bus(0, 8'h1A, 8'h60);
    bus(0, 8'h1B, 8'h00);
    bus(1, 8'h19, 8'hFF);
    bus(0, 8'h19, 8'h3F);
    $display("reset and registers done");
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h19, 8'(i) * 8'h09);
      bus(1, 8'h1A, 8'(i) * 8'h50 + 8'h05);
      chk(o1, 8'(i + 1) * 8'h22);
      chk(o2, 8'(i) * 8'h05);
      bus(0, 8'h1A, 8'(i) * 8'h50 + 8'h05);
    end
    $display("gain table done");
    bus(1, 8'h19, 8'h18);
    pulse(1);
    chk(o1, 8'h88);
    bus(1, 8'h19, 8'h1C);
    chk(o1, 8'h18);
    chk(o2, 8'h8C);
    pulse(0);
    chk(o1, 8'h88);
    chk(o2, 8'h0C);
    $display("sync switching done");
    bus(1, 8'h19, 8'h22);
    chk(o2, 8'h4E);
    @(posedge sys_clk);
    carrier_sense <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(o2, 8'h4E);
    @(posedge sys_clk);
    #1;
    chk(o2, 8'h0E);
    @(posedge sys_clk);
    carrier_sense <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pulse(0);
    chk(o2, 8'h4E);
    $display("freeze done");
    end_of_test();
  end
endmodule // dlgc_loop_gain_control_test
bind dlgc_loop_gain_control dlgc_sva u_sva (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .sync_detect,
  .carrier_sense, .freq_gain, .freq_comp_saturation, .clkrec_integral_gain, .clkrec_proportional_sel,
  .loops_frozen, .sync_phase);
